// ### verilog/psr_pkg.sv
// Package of constants and types for the serial-out shift register
package psr_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int PSR_STAGES = 8;
    localparam int PSR_LAST = PSR_STAGES - 1;
    localparam int PSR_SYNC_DEPTH = 3;

    // ----------------------------------------------------------------
    // Control pin bundle, bit positions
    // ----------------------------------------------------------------
    localparam int PSR_CTRL_W = 4;
    localparam int PSR_CTRL_SEL = 0;
    localparam int PSR_CTRL_CLK = 1;
    localparam int PSR_CTRL_BLK = 2;
    localparam int PSR_CTRL_CHAIN = 3;

    // ----------------------------------------------------------------
    // Reset values and pin levels
    // ----------------------------------------------------------------
    localparam logic [PSR_CTRL_W-1:0] PSR_CTRL_RST = 4'h1;
    localparam logic [PSR_STAGES-1:0] PSR_PAR_RST = 8'h00;
    localparam logic [PSR_STAGES-1:0] PSR_KNOWN_RST = 8'h00;
    localparam logic [PSR_STAGES-1:0] PSR_KNOWN_ALL = 8'hff;
    localparam logic PSR_PULL_LEVEL = 1'b0;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PSR_MODE_HOLD,
        PSR_MODE_CAPTURE,
        PSR_MODE_SHIFT
    } psr_mode_t;

endpackage : psr_pkg

// ### verilog/psr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module psr_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync2_r;
    logic [WIDTH-1:0] sync3_r;

    // ----------------------------------------------------------------
    // Chain
    // ----------------------------------------------------------------
    // First flop feeds only the second one
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST_VAL;
            sync2_r <= RST_VAL;
            sync3_r <= RST_VAL;
        end else begin
            meta_r <= pin_in;
            sync2_r <= meta_r;
            sync3_r <= sync2_r;
        end
    end

    // ----------------------------------------------------------------
    // Agreement filter
    // ----------------------------------------------------------------
    // Per bit: a change counts once second and third agree
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            level_out <= RST_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (sync2_r[i] == sync3_r[i]) begin
                    level_out[i] <= sync3_r[i];
                end
            end
        end
    end

endmodule : psr_pin_sync

// ### verilog/psr_shift_reg.sv
// Parallel or serial in, serial out shift register with open-drain outputs
`timescale 1ns/100ps

module psr_shift_reg (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic capture_select,
    input wire logic shift_clock,
    input wire logic clock_block,
    input wire logic chain_input,
    input wire logic [psr_pkg::PSR_STAGES-1:0] par_in,
    output logic serial_true_out,
    output logic serial_true_oe,
    output logic serial_inv_out,
    output logic serial_inv_oe,
    output logic last_stage_known
);
    import psr_pkg::*;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [PSR_CTRL_W-1:0] ctrl_pins;
    logic [PSR_CTRL_W-1:0] ctrl_lvl;
    logic [PSR_STAGES-1:0] par_lvl;
    logic sel_lvl;
    logic clk_lvl;
    logic blk_lvl;
    logic chain_lvl;
    logic clk_prev_r;
    logic blk_prev_r;
    logic clk_rise;
    logic blk_rise;
    logic shift_evt;
    logic [2:0] settle_r;
    logic armed_r;
    psr_mode_t mode;
    logic [PSR_STAGES-1:0] stage_r;
    logic [PSR_STAGES-1:0] stage_nxt;
    logic [PSR_STAGES-1:0] known_r;
    logic [PSR_STAGES-1:0] known_nxt;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Pins come from another domain; both bundles see equal latency so
    // data and clock stay aligned after filtering
    always_comb begin
        ctrl_pins = '0;
        ctrl_pins[PSR_CTRL_SEL] = capture_select;
        ctrl_pins[PSR_CTRL_CLK] = shift_clock;
        ctrl_pins[PSR_CTRL_BLK] = clock_block;
        ctrl_pins[PSR_CTRL_CHAIN] = chain_input;
    end

    psr_pin_sync #(
        .WIDTH(PSR_CTRL_W),
        .RST_VAL(PSR_CTRL_RST)
    ) u_ctrl_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_in(ctrl_pins),
        .level_out(ctrl_lvl)
    );

    psr_pin_sync #(
        .WIDTH(PSR_STAGES),
        .RST_VAL(PSR_PAR_RST)
    ) u_par_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .pin_in(par_in),
        .level_out(par_lvl)
    );

    assign sel_lvl = ctrl_lvl[PSR_CTRL_SEL];
    assign clk_lvl = ctrl_lvl[PSR_CTRL_CLK];
    assign blk_lvl = ctrl_lvl[PSR_CTRL_BLK];
    assign chain_lvl = ctrl_lvl[PSR_CTRL_CHAIN];

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    // Filtered levels sit at their reset values until the pin filter
    // has refilled, so a pin already high at release would look like
    // a rising edge; edges stay ignored until the hold-off runs out
    // Costs five cycles after release, far below any pin hold time
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            settle_r <= 3'h0;
        end else if (!armed_r) begin
            settle_r <= settle_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            armed_r <= 1'b0;
        end else if (settle_r == 3'(PSR_SYNC_DEPTH + 1)) begin
            armed_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            clk_prev_r <= 1'b1;
            blk_prev_r <= 1'b1;
        end else begin
            clk_prev_r <= clk_lvl;
            blk_prev_r <= blk_lvl;
        end
    end

    assign clk_rise = clk_lvl & ~clk_prev_r;
    assign blk_rise = blk_lvl & ~blk_prev_r;

    // Either input clocks while the other stays low
    assign shift_evt = armed_r & ((clk_rise & ~blk_lvl) | (blk_rise & ~clk_lvl));

    // ----------------------------------------------------------------
    // Mode selection
    // ----------------------------------------------------------------
    // Capture is level driven and needs no arming
    always_comb begin
        if (!sel_lvl) begin
            mode = PSR_MODE_CAPTURE;
        end else if (shift_evt) begin
            mode = PSR_MODE_SHIFT;
        end else begin
            mode = PSR_MODE_HOLD;
        end
    end

    // ----------------------------------------------------------------
    // Stage chain
    // ----------------------------------------------------------------
    always_comb begin
        case (mode)
            PSR_MODE_CAPTURE: begin
                // Followed every cycle, not on any shift edge
                stage_nxt = par_lvl;
            end
            PSR_MODE_SHIFT: begin
                stage_nxt = {stage_r[PSR_LAST-1:0], chain_lvl};
            end
            PSR_MODE_HOLD: begin
                stage_nxt = stage_r;
            end
            default: begin
                stage_nxt = stage_r;
            end
        endcase
    end

    // Deliberately no reset: contents are undefined until loaded
    always_ff @(posedge clk_sys) begin
        stage_r <= stage_nxt;
    end

    // ----------------------------------------------------------------
    // Known-content tracking
    // ----------------------------------------------------------------
    // Lets the system see when the last stage holds loaded data; bits
    // enter at stage 0 and march toward the output with the data
    always_comb begin
        case (mode)
            PSR_MODE_CAPTURE: begin
                known_nxt = PSR_KNOWN_ALL;
            end
            PSR_MODE_SHIFT: begin
                known_nxt = {known_r[PSR_LAST-1:0], 1'b1};
            end
            PSR_MODE_HOLD: begin
                known_nxt = known_r;
            end
            default: begin
                known_nxt = known_r;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            known_r <= PSR_KNOWN_RST;
        end else begin
            known_r <= known_nxt;
        end
    end

    assign last_stage_known = known_r[PSR_LAST];

    // ----------------------------------------------------------------
    // Open-drain outputs
    // ----------------------------------------------------------------
    // Driven level is always low; a high is only ever a release
    assign serial_true_out = PSR_PULL_LEVEL;
    assign serial_inv_out = PSR_PULL_LEVEL;

    // Taken straight from the last stage flop; during capture that
    // stage holds input H
    assign serial_true_oe = ~stage_r[PSR_LAST];
    assign serial_inv_oe = stage_r[PSR_LAST];

endmodule : psr_shift_reg

// ### sim/psr_shift_reg_assertions.sv
// Port-level checks for the serial-out shift register
`timescale 1ns/100ps
module psr_shift_reg_chk (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic capture_select,
    input wire logic shift_clock,
    input wire logic clock_block,
    input wire logic [psr_pkg::PSR_STAGES-1:0] par_in,
    input wire logic serial_true_out,
    input wire logic serial_true_oe,
    input wire logic serial_inv_out,
    input wire logic serial_inv_oe,
    input wire logic last_stage_known
);
    import psr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    chk_true_never_high: assert property (serial_true_out == 1'b0)
        else $error("true output driven high");
    chk_inv_never_high: assert property (serial_inv_out == 1'b0)
        else $error("inverted output driven high");
    chk_oe_opposite: assert property (last_stage_known |-> serial_true_oe != serial_inv_oe)
        else $error("output enables not complementary");
    // Seven samples cover the pin filter latency with margin
    chk_capture_follows: assert property ((!capture_select && $stable(par_in))[*7] |->
        serial_true_oe == !par_in[7] && serial_inv_oe == par_in[7])
        else $error("capture does not follow last parallel input");
    chk_capture_known: assert property ((!capture_select)[*7] |-> last_stage_known)
        else $error("capture leaves last stage unknown");
    chk_clk_high_hold: assert property ((capture_select && shift_clock && last_stage_known)[*8]
        |-> $stable(serial_true_oe))
        else $error("change while clock held high");
    chk_block_high_hold: assert property ((capture_select && clock_block && last_stage_known)[*8]
        |-> $stable(serial_inv_oe))
        else $error("change while clock block held high");
    chk_idle_hold: assert property ((capture_select && !shift_clock && !clock_block
        && last_stage_known)[*8] |-> $stable(serial_true_oe) && $stable(last_stage_known))
        else $error("change without a clock edge");
endmodule : psr_shift_reg_chk

bind psr_shift_reg psr_shift_reg_chk i_chk (.clk_sys, .arst_n, .capture_select, .shift_clock,
    .clock_block, .par_in, .serial_true_out, .serial_true_oe, .serial_inv_out, .serial_inv_oe,
    .last_stage_known);

// ### sim/psr_ctrl_model.sv
// Controller model: drives select and clock, reads the open-drain pins
`timescale 1ns/100ps
module psr_ctrl_model (
    input wire logic clk_sys,
    input wire logic true_oe,
    input wire logic inv_oe,
    output logic capture_select,
    output logic shift_clock,
    output logic true_pin,
    output logic inv_pin
);
    // Released pins read high through the pull-up
    assign true_pin = true_oe ? 1'b0 : 1'b1;
    assign inv_pin = inv_oe ? 1'b0 : 1'b1;
    initial begin
        capture_select = 1'b1;
        shift_clock = 1'b0;
    end
    // Ten cycles per level, well past the pin filter; select and clock change in the same step
    task automatic hold_lvl(input logic sel, input logic clk);
        capture_select = sel;
        shift_clock = clk;
        repeat (10) @(negedge clk_sys);
    endtask : hold_lvl
endmodule : psr_ctrl_model

// ### sim/piso_shift_register_8bit_tb_top.sv
// Self-checking bench for the serial-out shift register
`timescale 1ns/100ps
module piso_shift_register_8bit_tb_top;
    import psr_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic clock_block = 1'b0;
    logic chain_input = 1'b0;
    logic [PSR_STAGES-1:0] par_in = 8'h00;
    logic capture_select, shift_clock, true_out, true_oe, inv_out, inv_oe, known;
    logic true_pin, inv_pin;
    logic [7:0] mdl;
    logic [31:0] seed = 32'h45;
    int err_total = 0;
    int checked = 0;
    always #2.5 clk_sys = ~clk_sys;
    psr_shift_reg i_dut (.clk_sys, .arst_n, .capture_select, .shift_clock, .clock_block,
        .chain_input, .par_in, .serial_true_out(true_out), .serial_true_oe(true_oe),
        .serial_inv_out(inv_out), .serial_inv_oe(inv_oe), .last_stage_known(known));
    psr_ctrl_model i_ctrl (.clk_sys, .true_oe, .inv_oe, .capture_select, .shift_clock,
        .true_pin, .inv_pin);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic check(input string name, input logic seen, input logic exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %b seen %b", name, exp, seen);
        end
    endtask : check
    task automatic pins();
        check("true pin", true_pin, mdl[7]);
        check("inverted pin", inv_pin, ~mdl[7]);
        check("known", known, 1'b1);
        check("true drive", true_out, 1'b0);
        check("inverted drive", inv_out, 1'b0);
    endtask : pins
    task automatic results();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        results();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        check("known after reset", known, 1'b0);
        repeat (2) begin
            par_in = PSR_STAGES'(xs());
            mdl = par_in;
            i_ctrl.hold_lvl(1'b0, 1'b0);
            pins();
            // New parallel value with a clock edge: capture must win
            par_in = ~par_in;
            mdl = par_in;
            i_ctrl.hold_lvl(1'b0, 1'b1);
            i_ctrl.hold_lvl(1'b0, 1'b0);
            pins();
            for (int i = 0; i < 10; i++) begin
                void'(xs());
                chain_input = seed[3];
                par_in = PSR_STAGES'(seed >> 8);
                mdl = {mdl[6:0], chain_input};
                i_ctrl.hold_lvl(1'b1, 1'b0);
                if (i[0]) begin
                    clock_block = 1'b1;
                    i_ctrl.hold_lvl(1'b1, 1'b0);
                    clock_block = 1'b0;
                end else begin
                    i_ctrl.hold_lvl(1'b1, 1'b1);
                end
                i_ctrl.hold_lvl(1'b1, 1'b0);
                pins();
            end
            // Block rising together with the clock, or while the clock is high, must not shift
            clock_block = 1'b1;
            i_ctrl.hold_lvl(1'b1, 1'b1);
            clock_block = 1'b0;
            i_ctrl.hold_lvl(1'b1, 1'b1);
            clock_block = 1'b1;
            i_ctrl.hold_lvl(1'b1, 1'b1);
            clock_block = 1'b0;
            i_ctrl.hold_lvl(1'b1, 1'b0);
            pins();
        end
        results();
    end
endmodule : piso_shift_register_8bit_tb_top
